/* pfu_defs.svh */
// Purpose: Constants of the pin function unit: register indexes, reset values, field positions
// Assumes: Register byte address is four times the index
// Notes: Included by its bare name
`ifndef PFU_DEFS_SVH
`define PFU_DEFS_SVH
`define PFU_IDX_DIR_A 30'h05ffffc4
`define PFU_IDX_DIR_B 30'h05ffffc6
`define PFU_IDX_FH_A 30'h05ffffc8
`define PFU_IDX_FL_A 30'h05ffffca
`define PFU_IDX_FH_B 30'h05ffffcc
`define PFU_IDX_FL_B 30'h05ffffce
`define PFU_IDX_CAS 30'h05ffffee
`define PFU_RST_DIR 16'h0000
`define PFU_RST_FH_A 16'h3302
`define PFU_RST_FL_A 16'hff95
`define PFU_RST_FB 16'h0000
`define PFU_RST_CAS 16'h5fff
`define PFU_RSV_FH_A 16'h0002
`define PFU_RSV_FL_A 16'haa00
`define PFU_RSV_CAS 16'h0fff
`define PFU_CAS_HI_POS 14
`define PFU_CAS_LO_POS 12
`define PFU_CAS_SEL 2'h1
`define PFU_SIZE_BYTE 3'h0
`define PFU_SIZE_HALF 3'h1
`define PFU_TRANS_ACTIVE_BIT 1
`endif

/* pfu_pkg.sv */
// Purpose: Types of the pin function unit
// Assumes: Nothing
// Notes: Numbers live in pfu_defs.svh
`default_nettype none
package pfu_pkg;
  typedef logic [15:0] pfu_word_t;
  typedef enum logic [2:0] {KIND_NONE, KIND_IN, KIND_OUT, KIND_BIDIR, KIND_DIRIO} pfu_kind_e;
  typedef enum logic [2:0] {REG_NONE, REG_DIR_A, REG_DIR_B, REG_FH_A, REG_FL_A, REG_FH_B, REG_FL_B,
    REG_CAS} pfu_reg_e;
endpackage : pfu_pkg
`default_nettype wire

/* pfu_pin_slice.sv */
// Purpose: One multiplexed pin: input filter, function select, driver control
// Assumes: Slot 0 is the general I/O role
// Notes: All outputs registered; pad drive one cycle behind its sources, slot inputs five cycles behind the pad
`timescale 1ns/100ps
`default_nettype none
module pfu_pin_slice #(
  parameter pfu_pkg::pfu_kind_e KIND [4] = '{default: pfu_pkg::KIND_NONE}
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic [1:0] code,
  input wire logic dirBit,
  input wire logic [3:0] slotOut,
  input wire logic [3:0] slotOe,
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic [3:0] slotIn
);
  import pfu_pkg::*;
  // Input-only slots idle high so active-low requests stay quiet
  localparam logic [3:0] INACT = {KIND[3] == KIND_IN, KIND[2] == KIND_IN, KIND[1] == KIND_IN, KIND[0] == KIND_IN};
  logic sync1_r, sync2_r, sync3_r, level_r;
  logic [3:0] inMask, selMask, inNxt;
  pfu_kind_e selKind;
  wire level_nxt = (sync2_r == sync3_r) ? sync2_r : level_r;
  genvar s;
  for (s = 0; s < 4; s++)
  begin : g_slot
    assign inMask[s] = (KIND[s] == KIND_IN) || (KIND[s] == KIND_BIDIR) || (KIND[s] == KIND_DIRIO);
    assign selMask[s] = (code == 2'(s));
  end
  assign selKind = KIND[code];
  wire drives = (selKind == KIND_OUT) || (selKind == KIND_BIDIR) || (selKind == KIND_DIRIO);
  wire outNxt = drives & slotOut[code];
  wire oeNxt = (selKind == KIND_OUT) | ((selKind == KIND_BIDIR) & slotOe[code])
    | ((selKind == KIND_DIRIO) & dirBit);
  assign inNxt = (selMask & inMask & {4{level_r}}) | (~(selMask & inMask) & INACT);
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      // Start at the idle high level so no false edge follows reset
      {sync1_r, sync2_r, sync3_r, level_r} <= 4'hf;
      padOut <= 1'b0;
      padOe <= 1'b0;
      slotIn <= INACT;
    end
    else if (clockEnable)
    begin
      {sync1_r, sync2_r, sync3_r} <= {padIn, sync1_r, sync2_r};
      level_r <= level_nxt;
      padOut <= outNxt;
      padOe <= oeNxt;
      slotIn <= inNxt;
    end
  end
  dir_oe_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable && selKind == KIND_DIRIO |=> padOe == $past(dirBit)) else $error("dir bit not on driver");
  dir_ignored_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable && (selKind == KIND_IN || selKind == KIND_NONE) |=> !padOe) else $error("input pin driven");
  in_gate_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable |=> ((slotIn ^ INACT) & ~$past(selMask)) == 4'h0) else $error("unselected slot sees pin");
  filter_a: assert property (@(posedge clock) disable iff (reset)
    $changed(level_r) |-> $past(sync2_r) == $past(sync3_r)) else $error("filter passed a glitch");
endmodule : pfu_pin_slice
`default_nettype wire

/* pfu_top.sv */
// Purpose: Pin function unit for ports A and B with AHB-Lite register access
// Assumes: reset is the power-on reset; bus idle while clockEnable is low
// Notes: Zero wait state slave, every response OKAY
`timescale 1ns/100ps
`default_nettype none
`include "pfu_defs.svh"
module pfu_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pfu_pkg::pfu_word_t aPadIn,
  output pfu_pkg::pfu_word_t aPadOut,
  output pfu_pkg::pfu_word_t aPadOe,
  input wire pfu_pkg::pfu_word_t aPortOut,
  output pfu_pkg::pfu_word_t aPortIn,
  input wire pfu_pkg::pfu_word_t aFn1Out,
  input wire pfu_pkg::pfu_word_t aFn1Oe,
  output pfu_pkg::pfu_word_t aFn1In,
  input wire pfu_pkg::pfu_word_t aFn2Out,
  input wire pfu_pkg::pfu_word_t aFn2Oe,
  output pfu_pkg::pfu_word_t aFn2In,
  input wire pfu_pkg::pfu_word_t aFn3Out,
  input wire pfu_pkg::pfu_word_t aFn3Oe,
  output pfu_pkg::pfu_word_t aFn3In,
  input wire pfu_pkg::pfu_word_t bPadIn,
  output pfu_pkg::pfu_word_t bPadOut,
  output pfu_pkg::pfu_word_t bPadOe,
  input wire pfu_pkg::pfu_word_t bPortOut,
  output pfu_pkg::pfu_word_t bPortIn,
  input wire pfu_pkg::pfu_word_t bFn1Out,
  input wire pfu_pkg::pfu_word_t bFn1Oe,
  output pfu_pkg::pfu_word_t bFn1In,
  input wire pfu_pkg::pfu_word_t bFn2Out,
  input wire pfu_pkg::pfu_word_t bFn2Oe,
  output pfu_pkg::pfu_word_t bFn2In,
  input wire pfu_pkg::pfu_word_t bFn3Out,
  input wire pfu_pkg::pfu_word_t bFn3Oe,
  output pfu_pkg::pfu_word_t bFn3In,
  input wire logic [1:0] csIn,
  input wire logic [1:0] casIn,
  output logic [1:0] csPinOut
);
  import pfu_pkg::*;

  function automatic pfu_kind_e pick(input int s, input pfu_kind_e k1, input pfu_kind_e k2,
    input pfu_kind_e k3);
    pfu_kind_e k;
    k = (s == 0) ? KIND_DIRIO : (s == 1) ? k1 : (s == 2) ? k2 : k3;
    return k;
  endfunction : pick

  // Slot index equals the pin's select code
  function automatic pfu_kind_e kindA(input int p, input int s);
    pfu_kind_e k;
    k = KIND_NONE;
    case (p)
      15: k = pick(s, KIND_IN, KIND_NONE, KIND_IN);
      14: k = pick(s, KIND_IN, KIND_NONE, KIND_OUT);
      13: k = pick(s, KIND_IN, KIND_IN, KIND_IN);
      12: k = pick(s, KIND_IN, KIND_IN, KIND_OUT);
      11, 10: k = pick(s, KIND_BIDIR, KIND_DIRIO, KIND_NONE);
      9: k = pick(s, KIND_OUT, KIND_NONE, KIND_OUT);
      8: k = pick(s, KIND_IN, KIND_NONE, KIND_NONE);
      7, 6, 5, 4: k = pick(s, KIND_OUT, KIND_NONE, KIND_NONE);
      3: k = pick(s, KIND_OUT, KIND_IN, KIND_NONE);
      2, 0: k = pick(s, KIND_OUT, KIND_DIRIO, KIND_NONE);
      1: k = pick(s, KIND_OUT, KIND_OUT, KIND_NONE);
      default: k = KIND_NONE;
    endcase
    return k;
  endfunction : kindA

  function automatic pfu_kind_e kindB(input int p, input int s);
    pfu_kind_e k;
    k = KIND_NONE;
    case (p)
      15, 14: k = pick(s, KIND_IN, KIND_NONE, KIND_OUT);
      13, 12: k = pick(s, KIND_IN, KIND_BIDIR, KIND_OUT);
      11, 9: k = pick(s, KIND_OUT, KIND_OUT, KIND_NONE);
      10, 8: k = pick(s, KIND_IN, KIND_OUT, KIND_NONE);
      7, 6: k = pick(s, KIND_IN, KIND_OUT, KIND_OUT);
      default: k = pick(s, KIND_DIRIO, KIND_OUT, KIND_NONE);
    endcase
    return k;
  endfunction : kindB

  function automatic pfu_word_t merge(input pfu_word_t old, input logic [1:0] lane, input pfu_word_t data);
    pfu_word_t w;
    w = old;
    if (lane[0])
      w[7:0] = data[7:0];
    if (lane[1])
      w[15:8] = data[15:8];
    return w;
  endfunction : merge

  pfu_word_t dirA_r, dirB_r, fhA_r, flA_r, fhB_r, flB_r, cas_r;
  pfu_word_t dirA_nxt, dirB_nxt, fhA_nxt, flA_nxt, fhB_nxt, flB_nxt, cas_nxt, rdMux;
  logic wrPend_r;
  pfu_reg_e wrReg_r, addrReg;
  logic [1:0] wrLane_r, addrLane;
  logic [31:0] hrdata_r;
  logic hreadyout_r, hresp_r;
  logic [1:0] csPinOut_r;

  // Address phase decode
  wire addrTake = hsel & htrans[`PFU_TRANS_ACTIVE_BIT] & hready;
  wire [29:0] wordIdx = haddr[31:2];
  assign addrReg = (wordIdx == `PFU_IDX_DIR_A) ? REG_DIR_A :
                   (wordIdx == `PFU_IDX_DIR_B) ? REG_DIR_B :
                   (wordIdx == `PFU_IDX_FH_A) ? REG_FH_A :
                   (wordIdx == `PFU_IDX_FL_A) ? REG_FL_A :
                   (wordIdx == `PFU_IDX_FH_B) ? REG_FH_B :
                   (wordIdx == `PFU_IDX_FL_B) ? REG_FL_B :
                   (wordIdx == `PFU_IDX_CAS) ? REG_CAS : REG_NONE;
  // Registers fill the low halfword; upper lanes are not stored
  wire [1:0] byteLane = (haddr[1:0] == 2'h0) ? 2'b01 : (haddr[1:0] == 2'h1) ? 2'b10 : 2'b00;
  wire [1:0] halfLane = haddr[1] ? 2'b00 : 2'b11;
  assign addrLane = (hsize == `PFU_SIZE_BYTE) ? byteLane : (hsize == `PFU_SIZE_HALF) ? halfLane : 2'b11;

  // Data phase write, merged by byte lane
  wire pfu_word_t wdata = hwdata[15:0];
  wire wrDirA = wrPend_r && (wrReg_r == REG_DIR_A);
  wire wrDirB = wrPend_r && (wrReg_r == REG_DIR_B);
  wire wrFhA = wrPend_r && (wrReg_r == REG_FH_A);
  wire wrFlA = wrPend_r && (wrReg_r == REG_FL_A);
  wire wrFhB = wrPend_r && (wrReg_r == REG_FH_B);
  wire wrFlB = wrPend_r && (wrReg_r == REG_FL_B);
  wire wrCas = wrPend_r && (wrReg_r == REG_CAS);
  assign dirA_nxt = wrDirA ? merge(dirA_r, wrLane_r, wdata) : dirA_r;
  assign dirB_nxt = wrDirB ? merge(dirB_r, wrLane_r, wdata) : dirB_r;
  // Reserved bits forced high whatever software writes
  assign fhA_nxt = (wrFhA ? merge(fhA_r, wrLane_r, wdata) : fhA_r) | `PFU_RSV_FH_A;
  assign flA_nxt = (wrFlA ? merge(flA_r, wrLane_r, wdata) : flA_r) | `PFU_RSV_FL_A;
  assign fhB_nxt = wrFhB ? merge(fhB_r, wrLane_r, wdata) : fhB_r;
  assign flB_nxt = wrFlB ? merge(flB_r, wrLane_r, wdata) : flB_r;
  assign cas_nxt = (wrCas ? merge(cas_r, wrLane_r, wdata) : cas_r) | `PFU_RSV_CAS;

  // Read from next values so a read right after a write sees it
  assign rdMux = (addrReg == REG_DIR_A) ? dirA_nxt :
                 (addrReg == REG_DIR_B) ? dirB_nxt :
                 (addrReg == REG_FH_A) ? fhA_nxt :
                 (addrReg == REG_FL_A) ? flA_nxt :
                 (addrReg == REG_FH_B) ? fhB_nxt :
                 (addrReg == REG_FL_B) ? flB_nxt :
                 (addrReg == REG_CAS) ? cas_nxt : 16'h0000;

  // Power-on only; no other reset reaches these
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      dirA_r <= `PFU_RST_DIR;
      dirB_r <= `PFU_RST_DIR;
      fhA_r <= `PFU_RST_FH_A;
      flA_r <= `PFU_RST_FL_A;
      fhB_r <= `PFU_RST_FB;
      flB_r <= `PFU_RST_FB;
      cas_r <= `PFU_RST_CAS;
    end
    else if (clockEnable)
    begin
      {dirA_r, dirB_r, fhA_r, flA_r} <= {dirA_nxt, dirB_nxt, fhA_nxt, flA_nxt};
      {fhB_r, flB_r, cas_r} <= {fhB_nxt, flB_nxt, cas_nxt};
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wrPend_r <= 1'b0;
      wrReg_r <= REG_NONE;
      wrLane_r <= 2'b00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else if (clockEnable)
    begin
      wrPend_r <= addrTake & hwrite;
      wrReg_r <= addrReg;
      wrLane_r <= addrLane;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      if (addrTake && !hwrite)
        hrdata_r <= {16'h0000, rdMux};
    end
  end
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;

  // Per-pin select codes
  logic [1:0] codeA [16];
  logic [1:0] codeB [16];
  genvar p;
  for (p = 0; p < 16; p++)
  begin : g_pin
    if (p >= 9)
    begin : g_ah
      assign codeA[p] = fhA_r[2 * (p - 8) + 1 -: 2];
    end
    else if (p == 8)
    begin : g_a8
      assign codeA[p] = {1'b0, fhA_r[0]};
    end
    else if (p >= 4)
    begin : g_am
      assign codeA[p] = {1'b0, flA_r[2 * p]};
    end
    else
    begin : g_al
      assign codeA[p] = flA_r[2 * p + 1 -: 2];
    end
    if (p >= 8)
    begin : g_bh
      assign codeB[p] = fhB_r[2 * (p - 8) + 1 -: 2];
    end
    else
    begin : g_bl
      assign codeB[p] = flB_r[2 * p + 1 -: 2];
    end
    wire [3:0] aIn, bIn;
    // Each pin decided alone, no mode input exists
    pfu_pin_slice #(.KIND('{kindA(p, 0), kindA(p, 1), kindA(p, 2), kindA(p, 3)})) u_a (
      .clock(clock),
      .reset(reset),
      .clockEnable(clockEnable),
      .code(codeA[p]),
      .dirBit(dirA_r[p]),
      .slotOut({aFn3Out[p], aFn2Out[p], aFn1Out[p], aPortOut[p]}),
      .slotOe({aFn3Oe[p], aFn2Oe[p], aFn1Oe[p], 1'b0}),
      .padIn(aPadIn[p]),
      .padOut(aPadOut[p]),
      .padOe(aPadOe[p]),
      .slotIn(aIn)
    );
    pfu_pin_slice #(.KIND('{kindB(p, 0), kindB(p, 1), kindB(p, 2), kindB(p, 3)})) u_b (
      .clock(clock),
      .reset(reset),
      .clockEnable(clockEnable),
      .code(codeB[p]),
      .dirBit(dirB_r[p]),
      .slotOut({bFn3Out[p], bFn2Out[p], bFn1Out[p], bPortOut[p]}),
      .slotOe({bFn3Oe[p], bFn2Oe[p], bFn1Oe[p], 1'b0}),
      .padIn(bPadIn[p]),
      .padOut(bPadOut[p]),
      .padOe(bPadOe[p]),
      .slotIn(bIn)
    );
    assign {aFn3In[p], aFn2In[p], aFn1In[p], aPortIn[p]} = aIn;
    assign {bFn3In[p], bFn2In[p], bFn1In[p], bPortIn[p]} = bIn;
  end

  // Chip select pins shared with column strobes
  wire casHiSel = cas_r[`PFU_CAS_HI_POS +: 2] == `PFU_CAS_SEL;
  wire casLoSel = cas_r[`PFU_CAS_LO_POS +: 2] == `PFU_CAS_SEL;
  wire [1:0] csPinOut_nxt = {casLoSel ? casIn[1] : csIn[1], casHiSel ? casIn[0] : csIn[0]};
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      csPinOut_r <= 2'b11;
    else if (clockEnable)
      csPinOut_r <= csPinOut_nxt;
  end
  assign csPinOut = csPinOut_r;

  dir_reset_a: assert property (@(posedge clock) disable iff (reset)
    $fell(reset) |-> dirA_r == 16'h0000 && dirB_r == 16'h0000) else $error("direction not cleared");
  ctl_reset_a: assert property (@(posedge clock) disable iff (reset)
    $fell(reset) |-> fhA_r == 16'h3302 && flA_r == 16'hff95 && cas_r == 16'h5fff && fhB_r == 16'h0000
    && flB_r == 16'h0000) else $error("control reset value wrong");
  rsvd_ones_a: assert property (@(posedge clock) disable iff (reset)
    fhA_r[1] && flA_r[15] && flA_r[13] && flA_r[11] && flA_r[9]) else $error("reserved bit reads zero");
  word_write_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable && wrDirA && wrLane_r == 2'b11 |=> dirA_r == $past(hwdata[15:0])) else $error("direction write lost");
  byte_lane_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable && wrDirA && wrLane_r == 2'b10 |=> dirA_r[7:0] == $past(dirA_r[7:0])
    && dirA_r[15:8] == $past(hwdata[15:8])) else $error("byte lane write wrong");
  read_back_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable && addrTake && !hwrite && addrReg == REG_DIR_A && !wrPend_r
    |=> hrdata == {16'h0000, $past(dirA_r)}) else $error("direction read wrong");
  bus_okay_a: assert property (@(posedge clock) disable iff (reset)
    hreadyout && !hresp) else $error("bus not ready or error");
  top_code_a: assert property (@(posedge clock) disable iff (reset)
    clockEnable && fhA_r[15:14] == 2'b10 |=> !aPadOe[15] && aFn1In[15] && aFn3In[15])
    else $error("reserved top code acted");
  wr_dir_c: cover property (@(posedge clock) disable iff (reset) wrDirA ##1 aPadOe != 16'h0000);
  rd_c: cover property (@(posedge clock) disable iff (reset) addrTake && !hwrite && addrReg != REG_NONE);
  byte_c: cover property (@(posedge clock) disable iff (reset) wrPend_r && wrLane_r == 2'b01);
endmodule : pfu_top
`default_nettype wire

/* pfu_pin_world.sv */
// Purpose: Board side of the pins, resolving each pad level
// Assumes: Every pad has a weak pull-up
// Notes: The block's own driver wins over an external one
`timescale 1ns/100ps
`default_nettype none
module pfu_pin_world (
  input wire pfu_pkg::pfu_word_t padOut,
  input wire pfu_pkg::pfu_word_t padOe,
  input wire pfu_pkg::pfu_word_t extOe,
  input wire pfu_pkg::pfu_word_t extVal,
  output var pfu_pkg::pfu_word_t padIn
);
  import pfu_pkg::*;
  // Undriven pads float up, never to a level the simulator picks
  assign padIn = (padOe & padOut) | (~padOe & extOe & extVal) | (~padOe & ~extOe);
endmodule : pfu_pin_world
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the pin function unit
// Assumes: Zero wait state slave; pads settle within 8 cycles
// Notes: Pads resolved by pfu_pin_world
`timescale 1ns/100ps
`default_nettype none
`include "pfu_defs.svh"
module tb_top;
  import pfu_pkg::*;
  logic clock;
  logic reset = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, junk;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  pfu_word_t aPortOut = '0, aFn1Out = 16'h0020, aFn1Oe = '0, aFn2Out = 16'h0800, aFn2Oe = '0;
  pfu_word_t aFn3Out = 16'h4000, aFn3Oe = '0, bPortOut = 16'h0f0f, bFnOut = '0, aExtOe = '0, aExtVal = '0;
  pfu_word_t aPadIn, aPadOut, aPadOe, aPortIn, aFn1In, aFn2In, aFn3In, bPadIn, bPadOut, bPadOe;
  pfu_word_t bPortIn, bFn1In, bFn2In, bFn3In;
  logic clockEnable = 1'b1;
  logic [1:0] csIn = 2'h1, casIn = 2'h2, csPinOut;
  int nErrors = 0, totalChecks = 0;
  logic [29:0] idxTab [7] = '{`PFU_IDX_DIR_A, `PFU_IDX_DIR_B, `PFU_IDX_FH_A, `PFU_IDX_FL_A, `PFU_IDX_FH_B,
    `PFU_IDX_FL_B, `PFU_IDX_CAS};
  logic [15:0] rstTab [7] = '{16'h0000, 16'h0000, 16'h3302, 16'hff95, 16'h0000, 16'h0000, 16'h5fff};

  pfu_top i_dut (.clock(clock), .reset(reset), .clockEnable(clockEnable), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .aPadIn(aPadIn), .aPadOut(aPadOut),
    .aPadOe(aPadOe), .aPortOut(aPortOut), .aPortIn(aPortIn), .aFn1Out(aFn1Out), .aFn1Oe(aFn1Oe),
    .aFn1In(aFn1In), .aFn2Out(aFn2Out), .aFn2Oe(aFn2Oe), .aFn2In(aFn2In), .aFn3Out(aFn3Out),
    .aFn3Oe(aFn3Oe), .aFn3In(aFn3In), .bPadIn(bPadIn), .bPadOut(bPadOut), .bPadOe(bPadOe),
    .bPortOut(bPortOut), .bPortIn(bPortIn), .bFn1Out(bFnOut), .bFn1Oe(bFnOut), .bFn1In(bFn1In),
    .bFn2Out(bFnOut), .bFn2Oe(bFnOut), .bFn2In(bFn2In), .bFn3Out(bFnOut), .bFn3Oe(bFnOut),
    .bFn3In(bFn3In), .csIn(csIn),
    .casIn(casIn), .csPinOut(csPinOut));
  pfu_pin_world i_worldA (.padOut(aPadOut), .padOe(aPadOe), .extOe(aExtOe), .extVal(aExtVal),
    .padIn(aPadIn));
  pfu_pin_world i_worldB (.padOut(bPadOut), .padOe(bPadOe), .extOe(16'h0000), .extVal(16'h0000),
    .padIn(bPadIn));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] ra(input logic [29:0] idx);
    return {idx, 2'b00};
  endfunction : ra

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // No cycle count assumed: only the watchdog ends a hung wait
  task automatic waitReady();
    do
      @(posedge clock);
    while (hreadyout !== 1'b1);
  endtask : waitReady

  // Address phase held until ready, then data phase held until ready
  // Whole-word single transfers only
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask : xfer

  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    xfer(1'b1, ra(idx), d, junk);
  endtask : wr

  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    check(d, e);
  endtask : rdChk

  task automatic checkRegs();
    for (int i = 0; i < 7; i++)
    begin
      rdChk(ra(idxTab[i]), {16'h0000, rstTab[i]});
    end
  endtask : checkRegs

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask : settle

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : giveVerdict

  initial
  begin
    repeat (20000) @(posedge clock);
    nErrors++;
    giveVerdict();
  end

  initial
  begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    checkRegs();
    settle();
    check(32'(aPadOe & 16'h4030), 32'h4030);
    check(32'(aPadOut & 16'h4030), 32'h4020);
    check(32'(csPinOut), 32'h2);
    $display("test reset values done");
    wr(`PFU_IDX_DIR_B, 32'hffff00c3);
    rdChk(ra(`PFU_IDX_DIR_B), 32'h000000c3);
    wr(`PFU_IDX_DIR_B, 32'h00005ac3);
    rdChk(ra(`PFU_IDX_DIR_B), 32'h00005ac3);
    wr(`PFU_IDX_DIR_A, 32'h0000a5c3);
    rdChk(ra(`PFU_IDX_DIR_A), 32'h0000a5c3);
    wr(30'h05ffffd0, 32'hffffffff);
    rdChk(ra(30'h05ffffd0), 32'h0);
    settle();
    check(32'(bPadOe), 32'h5ac3);
    check(32'(bPadOut), 32'h0f0f);
    check(32'(bPortIn), 32'haf3f);
    check(32'(bFn1In), 32'hf5c0);
    check({bFn3In, bFn2In}, 32'h0);
    $display("test bus access done");
    // Reserved bits always written as 1
    wr(`PFU_IDX_FH_A, 32'h0002);
    wr(`PFU_IDX_FL_A, 32'haa00);
    for (int n = 0; n < 16; n++)
    begin
      wr(`PFU_IDX_DIR_A, 32'h1 << n);
      settle();
      check(32'(aPadOe), 32'h1 << n);
    end
    @(posedge clock);
    aPortOut <= 16'h5a3c;
    aExtOe <= 16'hff00;
    aExtVal <= 16'h2500;
    wr(`PFU_IDX_DIR_A, 32'h00ff);
    settle();
    check(32'(aPadOe), 32'h00ff);
    check(32'(aPadOut & 16'h00ff), 32'h003c);
    check(32'(aPortIn), 32'h253c);
    $display("test direction done");
    // Frozen pins must hold their drive until the enable returns
    @(posedge clock);
    clockEnable <= 1'b0;
    aPortOut <= 16'h5ac3;
    settle();
    check(32'(aPadOut & 16'h00ff), 32'h003c);
    @(posedge clock);
    clockEnable <= 1'b1;
    settle();
    check(32'(aPadOut & 16'h00ff), 32'h00c3);
    $display("test clock enable done");
    wr(`PFU_IDX_DIR_A, 32'h8000);
    for (int c = 0; c < 4; c++)
    begin
      wr(`PFU_IDX_FH_A, {16'h0, c[1:0], 14'h0002});
      settle();
      check(32'(aPadOe[15]), 32'(c == 0));
      check(32'(aFn1In[15]), 32'(c != 1));
      check(32'(aFn3In[15]), 32'(c != 3));
    end
    $display("test top pin codes done");
    @(posedge clock);
    aExtVal <= 16'h0800;
    wr(`PFU_IDX_DIR_A, 32'h0800);
    wr(`PFU_IDX_FH_A, 32'h0082);
    settle();
    check(32'(aPadOe[11]), 32'h1);
    check(32'(aPadOut[11]), 32'h1);
    wr(`PFU_IDX_DIR_A, 32'h0);
    settle();
    check(32'(aPadOe[11]), 32'h0);
    check(32'(aFn2In[11]), 32'h1);
    check(32'(aFn1In[11]), 32'h0);
    wr(`PFU_IDX_DIR_A, 32'h0800);
    wr(`PFU_IDX_FH_A, 32'h0042);
    settle();
    check(32'(aPadOe[11]), 32'h0);
    @(posedge clock);
    aFn1Oe <= 16'h0800;
    aFn1Out <= 16'h0820;
    settle();
    check(32'(aPadOe[11]), 32'h1);
    check(32'(aPadOut[11]), 32'h1);
    $display("test timer and parity roles done");
    wr(`PFU_IDX_CAS, 32'h0fff);
    settle();
    check(32'(csPinOut), 32'h1);
    wr(`PFU_IDX_CAS, 32'h1fff);
    settle();
    check(32'(csPinOut), 32'h3);
    $display("test strobe pins done");
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    checkRegs();
    $display("test second reset done");
    giveVerdict();
  end
endmodule : tb_top
`default_nettype wire
